//--- bench/lpc_regs_sva.sv
// port assertions of the comparator register bank
`timescale 1ns/1ps
`default_nettype none
module lpc_regs_sva
    import lpc_pkg::*;
#(
    parameter int STARTUP_CYCLES = 4
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    // analog side and interrupt
    input wire logic comp_out_pin,
    input wire lpc_analog_cfg_t analog_cfg,
    input wire logic irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0) else $error("rdata not zero when idle");
    enable_read_a: assert property (rd && addr == 12'h308 |=> rdata[31:4] == 28'h0)
        else $error("enable read has upper bits");
    ref_reset_a: assert property ($rose(rst_n) |-> analog_cfg.ref_sel == 4'h4) else $error("ref reset not four");
    ref_write_a: assert property (wr && addr == 12'h508 |=> {28'h0, analog_cfg.ref_sel} == ($past(wdata) & 32'hf))
        else $error("ref code not taken");
    ref_hold_a: assert property (!(wr && addr == 12'h508) |=> $stable(analog_cfg.ref_sel))
        else $error("ref code moved");
    ext_write_a: assert property (wr && addr == 12'h50c |=> {29'h0, analog_cfg.ext_ref_sel} == ($past(wdata) & 32'h7))
        else $error("external select not taken");
    ref_read_a: assert property (rd && addr == 12'h508 |=> rdata == {28'h0, analog_cfg.ref_sel})
        else $error("ref read mismatch");
    sample_pulse_a: assert property (analog_cfg.sample |=> !analog_cfg.sample) else $error("sample not a pulse");
    unmapped_read_a: assert property (rd && addr == 12'h7fc |=> rdata == 32'h0) else $error("unmapped read not zero");
    cover property (irq);
    cover property (analog_cfg.sample);
    cover property (rd && addr == 12'h7fc);
endmodule
bind lpc_regs lpc_regs_sva #(.STARTUP_CYCLES(STARTUP_CYCLES)) lpc_regs_sva_i (.clock(clock), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .comp_out_pin(comp_out_pin),
    .analog_cfg(analog_cfg), .irq(irq));
`default_nettype wire

//--- bench/lpc_regs_tb_top.sv
// self-checking bench of the comparator register bank
`timescale 1ns/1ps
`default_nettype none
module lpc_regs_tb_top
    import lpc_pkg::*;
;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] addr = 12'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic comp_out_pin = 1'b0;
    logic [31:0] rdata;
    logic [31:0] rv;
    lpc_analog_cfg_t analog_cfg;
    logic irq;
    logic seen_sample = 1'b0;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    // address, write data, expected read back
    logic [75:0] rows [10] = '{{12'h508, 32'h0, 32'h0}, {12'h508, 32'h6, 32'h6}, {12'h508, 32'h8, 32'h8},
        {12'h508, 32'hf, 32'hf}, {12'h508, 32'h7, 32'h7}, {12'h50c, 32'h5, 32'h5}, {12'h504, 32'hffffffff, 32'h7},
        {12'h520, 32'hf, 32'h3}, {12'h538, 32'h3, 32'h1}, {12'h7fc, 32'hffffffff, 32'h0}};
    // short startup keeps the run small
    lpc_regs #(.STARTUP_CYCLES(4)) lpc_regs_i (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .comp_out_pin(comp_out_pin), .analog_cfg(analog_cfg), .irq(irq));
    always #2 clock = ~clock;
    task automatic end_sim();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (analog_cfg.sample === 1'b1) seen_sample <= 1'b1;
        if (cycles == 5000) begin
            num_errors = num_errors + 1;
            end_sim();
        end
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic settle();
        repeat (2) @(posedge clock);
        #1;
    endtask
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        check("ref_sel reset", {28'h0, analog_cfg.ref_sel}, 32'h4);
        check("core off at reset", {31'h0, analog_cfg.enable}, 32'h0);
        rd_reg(12'h508, rv);
        check("reference_select reset", rv, 32'h4);
        rd_reg(12'h308, rv);
        check("interrupt_enable_clear reset", rv, 32'h0);
        foreach (rows[i]) begin
            wr_reg(rows[i][75:64], rows[i][63:32]);
            rd_reg(rows[i][75:64], rv);
            check("row read back", rv, rows[i][31:0]);
        end
        check("ref_sel external", {28'h0, analog_cfg.ref_sel}, 32'h7);
        check("ext_ref_sel", {29'h0, analog_cfg.ext_ref_sel}, 32'h5);
        check("pin_sel", {29'h0, analog_cfg.pin_sel}, 32'h7);
        check("detect_mode", {30'h0, analog_cfg.detect_mode}, 32'h3);
        check("hysteresis", {31'h0, analog_cfg.hysteresis}, 32'h1);
        wr_reg(12'h304, 32'hf);
        rd_reg(12'h308, rv);
        check("enables all set", rv, 32'hf);
        wr_reg(12'h308, 32'ha);
        rd_reg(12'h308, rv);
        check("enables after clear", rv, 32'h5);
        wr_reg(12'h308, 32'h0);
        rd_reg(12'h308, rv);
        check("zero write keeps", rv, 32'h5);
        comp_out_pin <= 1'b1;
        wr_reg(12'h200, 32'h1);
        wr_reg(12'h500, 32'h1);
        wr_reg(12'h000, 32'h1);
        repeat (50) if (irq !== 1'b1) begin
            @(posedge clock);
            #1;
        end
        check("irq on ready", {31'h0, irq}, 32'h1);
        check("core running", {31'h0, analog_cfg.enable}, 32'h1);
        rd_reg(12'h100, rv);
        check("ready flag", rv, 32'h1);
        settle();
        rd_reg(12'h400, rv);
        check("result sampled", rv, 32'h1);
        check("sample pulse seen", {31'h0, seen_sample}, 32'h1);
        wr_reg(12'h308, 32'h1);
        settle();
        check("irq masked", {31'h0, irq}, 32'h0);
        wr_reg(12'h608, 32'h1);
        settle();
        check("irq from status", {31'h0, irq}, 32'h1);
        wr_reg(12'h604, 32'h1);
        settle();
        check("irq after status clear", {31'h0, irq}, 32'h0);
        // reset again in mid-run: everything returns to its reset values
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        check("ref_sel after reset", {28'h0, analog_cfg.ref_sel}, 32'h4);
        check("irq after reset", {31'h0, irq}, 32'h0);
        check("core off after reset", {31'h0, analog_cfg.enable}, 32'h0);
        rd_reg(12'h508, rv);
        check("reference_select after reset", rv, 32'h4);
        rd_reg(12'h308, rv);
        check("enables after reset", rv, 32'h0);
        end_sim();
    end
endmodule
`default_nettype wire

//--- core/lpc_params.svh
// register offsets, field positions, reset values and timing counts of the comparator registers
`ifndef LPC_PARAMS_SVH
`define LPC_PARAMS_SVH
`define LPC_OFF_EVT_READY 12'h100
`define LPC_OFF_EVT_DOWN 12'h104
`define LPC_OFF_EVT_UP 12'h108
`define LPC_OFF_EVT_CROSS 12'h10c
`define LPC_OFF_SHORTS 12'h200
`define LPC_OFF_INT_ENABLE_SET 12'h304
`define LPC_OFF_INT_ENABLE_CLEAR 12'h308
`define LPC_OFF_RESULT 12'h400
`define LPC_OFF_ENABLE 12'h500
`define LPC_OFF_PIN_SELECT 12'h504
`define LPC_OFF_REF_SELECT 12'h508
`define LPC_OFF_EXT_REF_SELECT 12'h50c
`define LPC_OFF_DETECT_CONFIG 12'h520
`define LPC_OFF_HYSTERESIS 12'h538
`define LPC_OFF_TASKS 12'h000
`define LPC_OFF_INT_STATUS 12'h600
`define LPC_OFF_INT_STATUS_CLEAR 12'h604
`define LPC_OFF_INT_STATUS_ENABLE 12'h608
`define LPC_BIT_READY 0
`define LPC_BIT_DOWN 1
`define LPC_BIT_UP 2
`define LPC_BIT_CROSS 3
`define LPC_BIT_TASK_START 0
`define LPC_BIT_TASK_STOP 1
`define LPC_BIT_TASK_SAMPLE 2
`define LPC_RST_REF_SELECT 4'h4
`define LPC_REF_EXTERNAL 4'h7
`define LPC_STARTUP_NS 134000
`define LPC_CLK_PERIOD_NS 4
`define LPC_STARTUP_CYCLES ((`LPC_STARTUP_NS + `LPC_CLK_PERIOD_NS - 1) / `LPC_CLK_PERIOD_NS)
`endif

//--- core/lpc_pkg.sv
// types shared by the comparator register bank
package lpc_pkg;
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } lpc_bus_req_t;
    typedef struct packed {
        logic enable;
        logic [3:0] ref_sel;
        logic [2:0] ext_ref_sel;
        logic [2:0] pin_sel;
        logic [1:0] detect_mode;
        logic hysteresis;
        logic sample;
    } lpc_analog_cfg_t;
    typedef enum logic [1:0] {
        LPC_OFF,
        LPC_STARTING,
        LPC_RUNNING
    } lpc_state_t;
endpackage

//--- core/lpc_regs.sv
// register bank and control of the low-power comparator
// What this block does
// - writing one to clear register bits 0..3 disables the legacy ready/down/up/cross event interrupts
// - reference codes 0..6 pick one to seven eighths of supply
// - reference code 7 routes the external reference chosen by external select
// - reference codes 8..15 pick odd sixteenths of supply, 1/16 to 15/16
// - reference select resets to four, five eighths of supply
// - ready event raised once comparator started and output valid
// - ready-to-sample shortcut triggers a sample automatically on ready
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "lpc_params.svh"
module lpc_regs
    import lpc_pkg::*;
#(
    parameter int STARTUP_CYCLES = `LPC_STARTUP_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // analog comparator core
    input wire logic comp_out_pin,
    output lpc_analog_cfg_t analog_cfg,
    // interrupt
    output logic irq
);
    lpc_bus_req_t req;
    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // comparator output arrives from the analog domain
    logic comp_meta, comp_sync, comp_prev;
    logic next_comp_meta, next_comp_sync, next_comp_prev;

    lpc_state_t state, next_state;
    logic [31:0] startup_cnt, next_startup_cnt;
    logic [3:0] int_en, next_int_en;
    logic [3:0] events, next_events;
    logic [3:0] int_status, next_int_status;
    logic [3:0] status_en, next_status_en;
    logic [4:0] shorts, next_shorts;
    logic enable, next_enable;
    logic [2:0] pin_sel, next_pin_sel;
    logic [3:0] ref_sel, next_ref_sel;
    logic [2:0] ext_ref_sel, next_ext_ref_sel;
    logic [1:0] detect_mode, next_detect_mode;
    logic hysteresis, next_hysteresis;
    logic result, next_result;
    logic [31:0] next_rdata;
    lpc_analog_cfg_t next_analog_cfg;
    logic next_irq;

    function automatic logic hit(input lpc_bus_req_t r, input logic [11:0] off);
        hit = r.wr && (r.addr == off);
    endfunction

    logic [3:0] fire;
    logic task_start, task_stop, task_sample;
    logic ready_d, next_ready_d;
    logic do_sample;

    // synchroniser: the second stage feeds logic, the third keeps its previous value for edge detection
    always_comb begin
        next_comp_meta = comp_out_pin;
        next_comp_sync = comp_meta;
        next_comp_prev = comp_sync;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            comp_meta <= 1'b0;
            comp_sync <= 1'b0;
            comp_prev <= 1'b0;
        end else begin
            comp_meta <= next_comp_meta;
            comp_sync <= next_comp_sync;
            comp_prev <= next_comp_prev;
        end
    end

    // task strobes decoded straight from the write port
    always_comb begin
        task_start = hit(req, `LPC_OFF_TASKS) && req.wdata[`LPC_BIT_TASK_START];
        task_stop = hit(req, `LPC_OFF_TASKS) && req.wdata[`LPC_BIT_TASK_STOP];
        task_sample = hit(req, `LPC_OFF_TASKS) && req.wdata[`LPC_BIT_TASK_SAMPLE];
        // shortcut lands the cycle after ready, once the core is running
        do_sample = task_sample || (shorts[0] && ready_d);
    end

    // comparator control
    always_comb begin
        fire = 4'h0;
        next_state = state;
        next_startup_cnt = startup_cnt;
        next_result = result;
        case (state)
            LPC_OFF: begin
                if (task_start && enable) begin
                    next_state = LPC_STARTING;
                    next_startup_cnt = 32'h0;
                end
            end
            LPC_STARTING: begin
                if (task_stop || !enable) begin
                    next_state = LPC_OFF;
                end else if (startup_cnt == STARTUP_CYCLES - 1) begin
                    fire[`LPC_BIT_READY] = 1'b1;
                    if (shorts[1]) begin
                        next_state = LPC_OFF;
                    end else begin
                        next_state = LPC_RUNNING;
                    end
                end else begin
                    next_startup_cnt = startup_cnt + 32'h1;
                end
            end
            LPC_RUNNING: begin
                if (comp_sync != comp_prev) begin
                    fire[`LPC_BIT_CROSS] = 1'b1;
                    fire[`LPC_BIT_DOWN] = !comp_sync;
                    fire[`LPC_BIT_UP] = comp_sync;
                end
                if (do_sample) begin
                    next_result = comp_sync;
                end
                // crossing shortcuts stop the core in the cycle of the event
                if (task_stop || !enable || (shorts[4:1] & fire) != 4'h0) begin
                    next_state = LPC_OFF;
                end
            end
            default: begin
                next_state = LPC_OFF;
            end
        endcase
        next_ready_d = fire[`LPC_BIT_READY];
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= LPC_OFF;
            startup_cnt <= 32'h0;
            ready_d <= 1'b0;
            result <= 1'b0;
        end else begin
            state <= next_state;
            startup_cnt <= next_startup_cnt;
            ready_d <= next_ready_d;
            result <= next_result;
        end
    end

    // events and interrupts: a hardware set wins over a software clear
    always_comb begin
        next_events = events;
        if (hit(req, `LPC_OFF_EVT_READY)) begin
            next_events[`LPC_BIT_READY] = req.wdata[0];
        end
        if (hit(req, `LPC_OFF_EVT_DOWN)) begin
            next_events[`LPC_BIT_DOWN] = req.wdata[0];
        end
        if (hit(req, `LPC_OFF_EVT_UP)) begin
            next_events[`LPC_BIT_UP] = req.wdata[0];
        end
        if (hit(req, `LPC_OFF_EVT_CROSS)) begin
            next_events[`LPC_BIT_CROSS] = req.wdata[0];
        end
        next_events = next_events | fire;
        next_int_status = int_status;
        if (hit(req, `LPC_OFF_INT_STATUS_CLEAR)) begin
            next_int_status = int_status & ~req.wdata[3:0];
        end
        next_int_status = next_int_status | fire;
        next_int_en = int_en;
        if (hit(req, `LPC_OFF_INT_ENABLE_SET)) begin
            next_int_en = int_en | req.wdata[3:0];
        end
        // only written ones disable, zeros leave an enable alone
        if (hit(req, `LPC_OFF_INT_ENABLE_CLEAR)) begin
            next_int_en = int_en & ~req.wdata[3:0];
        end
        next_status_en = status_en;
        if (hit(req, `LPC_OFF_INT_STATUS_ENABLE)) begin
            next_status_en = req.wdata[3:0];
        end
        // legacy enables gate the event flags, beside the sticky status block
        next_irq = ((events & int_en) != 4'h0) || ((int_status & status_en) != 4'h0);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            events <= 4'h0;
            int_status <= 4'h0;
            int_en <= 4'h0;
            status_en <= 4'h0;
            irq <= 1'b0;
        end else begin
            events <= next_events;
            int_status <= next_int_status;
            int_en <= next_int_en;
            status_en <= next_status_en;
            irq <= next_irq;
        end
    end

    // configuration registers
    always_comb begin
        next_shorts = shorts;
        if (hit(req, `LPC_OFF_SHORTS)) begin
            next_shorts = req.wdata[4:0];
        end
        next_enable = enable;
        if (hit(req, `LPC_OFF_ENABLE)) begin
            next_enable = req.wdata[0];
        end
        next_pin_sel = pin_sel;
        if (hit(req, `LPC_OFF_PIN_SELECT)) begin
            next_pin_sel = req.wdata[2:0];
        end
        next_ref_sel = ref_sel;
        if (hit(req, `LPC_OFF_REF_SELECT)) begin
            next_ref_sel = req.wdata[3:0];
        end
        next_ext_ref_sel = ext_ref_sel;
        if (hit(req, `LPC_OFF_EXT_REF_SELECT)) begin
            next_ext_ref_sel = req.wdata[2:0];
        end
        next_detect_mode = detect_mode;
        if (hit(req, `LPC_OFF_DETECT_CONFIG)) begin
            next_detect_mode = req.wdata[1:0];
        end
        next_hysteresis = hysteresis;
        if (hit(req, `LPC_OFF_HYSTERESIS)) begin
            next_hysteresis = req.wdata[0];
        end
        // raw code to the core, whose ladder decodes 0..6, 7 and 8..15; one cycle after the write
        next_analog_cfg = '{enable: (next_state != LPC_OFF), ref_sel: next_ref_sel,
            ext_ref_sel: next_ext_ref_sel, pin_sel: next_pin_sel, detect_mode: next_detect_mode,
            hysteresis: next_hysteresis, sample: do_sample};
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            shorts <= 5'h0;
            enable <= 1'b0;
            pin_sel <= 3'h0;
            ref_sel <= `LPC_RST_REF_SELECT;
            ext_ref_sel <= 3'h0;
            detect_mode <= 2'h0;
            hysteresis <= 1'b0;
            analog_cfg <= '{enable: 1'b0, ref_sel: `LPC_RST_REF_SELECT, ext_ref_sel: 3'h0,
                pin_sel: 3'h0, detect_mode: 2'h0, hysteresis: 1'b0, sample: 1'b0};
        end else begin
            shorts <= next_shorts;
            enable <= next_enable;
            pin_sel <= next_pin_sel;
            ref_sel <= next_ref_sel;
            ext_ref_sel <= next_ext_ref_sel;
            detect_mode <= next_detect_mode;
            hysteresis <= next_hysteresis;
            analog_cfg <= next_analog_cfg;
        end
    end

    // read port: data stand only in the cycle after the strobe
    always_comb begin
        next_rdata = 32'h0;
        if (req.rd) begin
            case (req.addr)
                `LPC_OFF_EVT_READY: next_rdata = {31'h0, events[`LPC_BIT_READY]};
                `LPC_OFF_EVT_DOWN: next_rdata = {31'h0, events[`LPC_BIT_DOWN]};
                `LPC_OFF_EVT_UP: next_rdata = {31'h0, events[`LPC_BIT_UP]};
                `LPC_OFF_EVT_CROSS: next_rdata = {31'h0, events[`LPC_BIT_CROSS]};
                `LPC_OFF_SHORTS: next_rdata = {27'h0, shorts};
                `LPC_OFF_INT_ENABLE_SET: next_rdata = {28'h0, int_en};
                `LPC_OFF_INT_ENABLE_CLEAR: next_rdata = {28'h0, int_en};
                `LPC_OFF_RESULT: next_rdata = {31'h0, result};
                `LPC_OFF_ENABLE: next_rdata = {31'h0, enable};
                `LPC_OFF_PIN_SELECT: next_rdata = {29'h0, pin_sel};
                `LPC_OFF_REF_SELECT: next_rdata = {28'h0, ref_sel};
                `LPC_OFF_EXT_REF_SELECT: next_rdata = {29'h0, ext_ref_sel};
                `LPC_OFF_DETECT_CONFIG: next_rdata = {30'h0, detect_mode};
                `LPC_OFF_HYSTERESIS: next_rdata = {31'h0, hysteresis};
                `LPC_OFF_INT_STATUS: next_rdata = {28'h0, int_status};
                `LPC_OFF_INT_STATUS_ENABLE: next_rdata = {28'h0, status_en};
                default: next_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata <= 32'h0;
        end else begin
            rdata <= next_rdata;
        end
    end
endmodule
`default_nettype wire
